/* bmc_pkg.sv */
`default_nettype none
package bmc_pkg;
   // ---------------------------------------------
   // Register map
   // ---------------------------------------------
   localparam logic [11:0] BMC_OFS_CFG  = 12'h000;
   localparam logic [11:0] BMC_OFS_STS  = 12'h004;
   localparam logic [11:0] BMC_OFS_MSK  = 12'h008;
   localparam int BMC_ADDR_W = 12;
   localparam int BMC_NINIT  = 5;
   // ---------------------------------------------
   // Field layout of the configuration word
   // ---------------------------------------------
   localparam int BMC_POS_ERR_LO = 16;
   localparam int BMC_POS_WAIT   = 6;
   localparam int BMC_POS_ARB_LO = 0;
   localparam int BMC_ARB_W      = 3;
   // Initiator index within the enable field
   localparam int BMC_INI_CPU_INSTR = 0;
   localparam int BMC_INI_CPU_DATA  = 1;
   localparam int BMC_INI_DMA       = 2;
   localparam int BMC_INI_DEBUG     = 3;
   localparam int BMC_INI_SHARED    = 4;
   // ---------------------------------------------
   // Reset values and mode codes
   // ---------------------------------------------
   localparam logic [4:0] BMC_RST_ERR_EN = 5'h1F;
   localparam logic       BMC_RST_WAIT   = 1'b1;
   localparam logic [2:0] BMC_ARB_MODE0  = 3'h0;
   localparam logic [2:0] BMC_ARB_MODE1  = 3'h1;
   localparam logic [2:0] BMC_ARB_MODE2  = 3'h2;
   localparam logic [2:0] BMC_RST_ARB    = BMC_ARB_MODE1;
   // Cycles the data RAM waits for address setup
   localparam logic [1:0] BMC_DRAM_WAIT_CYC = 2'h1;
   typedef enum logic [1:0] {
      BMC_DR_IDLE = 2'b01,
      BMC_DR_WAIT = 2'b10
   } bmc_dram_st_t;
endpackage
`default_nettype wire

/* bmc_top.sv */
// What this block does
// RULE1: Shared bus unmapped access raises error if enabled
// RULE2: Debug unit unmapped access raises error if enabled
// RULE3: DMA unmapped access raises error if enabled
// RULE4: CPU data error enabled, suppressed in debug
// RULE5: CPU fetch error enabled, suppressed in debug
// RULE6: Wait bit adds one data RAM wait state
// RULE7: Three-bit code selects arbitration mode 0..2
// RULE8: Arbitration code resets to mode 1
// RULE9: Software never writes reserved codes 011..111
// RULE10: Unimplemented configuration bits read as zero
// RULE11: Error enables and wait bit reset to one
`default_nettype none
module bmc_top (
   // Clock and reset
   input  wire logic                       clock,
   input  wire logic                       rst,
   // APB slave
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [bmc_pkg::BMC_ADDR_W-1:0] paddr,
   input  wire logic [31:0]                pwdata,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   // Unmapped access strobes, one per initiator
   input  wire logic [bmc_pkg::BMC_NINIT-1:0] unmapped_access,
   input  wire logic                       cpu_debug_mode,
   output logic      [bmc_pkg::BMC_NINIT-1:0] bus_error,
   // CPU access to data RAM
   input  wire logic                       cpu_dram_req,
   output logic                            cpu_dram_ack,
   // Arbitration mode and data RAM wait state to the matrix
   output logic      [2:0]                 arbitration_mode_sel,
   output logic      [2:0]                 arb_mode_onehot,
   output logic                            data_ram_wait_state,
   // Interrupt
   output logic                            irq
);
   import bmc_pkg::*;

   // ---------------------------------------------
   // State
   // ---------------------------------------------
   typedef struct packed {
      logic [BMC_NINIT-1:0] err_en;
      logic                 wait_st;
      logic [2:0]           arb;
      logic [BMC_NINIT-1:0] sts;
      logic [BMC_NINIT-1:0] msk;
      logic [31:0]          rdata;
      logic                 ready;
      logic                 slverr;
      logic [BMC_NINIT-1:0] berr;
      logic [2:0]           arb_oh;
      logic                 irq;
      logic                 ack;
      logic [1:0]           wcnt;
      bmc_dram_st_t         dst;
   } bmc_state_t;

   bmc_state_t s_q;
   bmc_state_t s_d;

   logic [BMC_NINIT-1:0] err_hit;
   logic [BMC_NINIT-1:0] dbg_gate;

   // ---------------------------------------------
   // Error qualification per initiator
   // ---------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < BMC_NINIT; gi++) begin : g_err
         // CPU ports stop checking while halted in debug
         if (gi == BMC_INI_CPU_INSTR || gi == BMC_INI_CPU_DATA) begin : g_cpu
            assign dbg_gate[gi] = cpu_debug_mode; // [RULE4] [RULE5]
         end else begin : g_oth
            assign dbg_gate[gi] = 1'b0;
         end
         // [RULE1] [RULE2] [RULE3]
         assign err_hit[gi] = unmapped_access[gi] & s_q.err_en[gi] & ~dbg_gate[gi];
      end
   endgenerate

   logic        setup_ph;
   logic        access_done;
   logic        hit_cfg;
   logic        hit_sts;
   logic        hit_msk;
   logic [31:0] cfg_word;

   // ---------------------------------------------
   // Bus decode
   // ---------------------------------------------
   assign setup_ph    = psel & ~penable;
   assign access_done = psel & penable & s_q.ready;
   assign hit_cfg     = (paddr == BMC_OFS_CFG);
   assign hit_sts     = (paddr == BMC_OFS_STS);
   assign hit_msk     = (paddr == BMC_OFS_MSK);

   always_comb begin
      cfg_word = 32'h0000_0000; // [RULE10]
      cfg_word[BMC_POS_ERR_LO +: BMC_NINIT] = s_q.err_en;
      cfg_word[BMC_POS_WAIT] = s_q.wait_st;
      cfg_word[BMC_POS_ARB_LO +: BMC_ARB_W] = s_q.arb;
   end

   // ---------------------------------------------
   // Next state
   // ---------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.ready  = 1'b0;
      s_d.slverr = 1'b0;
      s_d.ack    = 1'b0;

      // Answer one cycle after setup; zero-wait access
      if (setup_ph) begin
         s_d.ready = 1'b1;
         s_d.rdata = 32'h0000_0000;
         if (hit_cfg) begin
            s_d.rdata = cfg_word;
         end else if (hit_sts) begin
            s_d.rdata[BMC_NINIT-1:0] = s_q.sts;
         end else if (hit_msk) begin
            s_d.rdata[BMC_NINIT-1:0] = s_q.msk;
         end else begin
            s_d.slverr = 1'b1;
         end
      end

      if (access_done && pwrite) begin
         if (hit_cfg) begin
            s_d.err_en  = pwdata[BMC_POS_ERR_LO +: BMC_NINIT];
            s_d.wait_st = pwdata[BMC_POS_WAIT];
            // Reserved codes are stored as written; matrix
            // behaviour for them is left to software
            s_d.arb = pwdata[BMC_POS_ARB_LO +: BMC_ARB_W]; // [RULE9]
         end
         if (hit_msk) begin
            s_d.msk = pwdata[BMC_NINIT-1:0];
         end
      end

      // Write-one-to-clear, new events win over the clear
      if (access_done && pwrite && hit_sts) begin
         s_d.sts = (s_q.sts & ~pwdata[BMC_NINIT-1:0]) | err_hit;
      end else begin
         s_d.sts = s_q.sts | err_hit;
      end

      s_d.berr = err_hit; // [RULE1] [RULE2] [RULE3] [RULE4] [RULE5]
      s_d.irq  = |(s_d.sts & s_d.msk);

      // Decode of the mode code; reserved codes select none
      case (s_d.arb) // [RULE7]
         BMC_ARB_MODE0: s_d.arb_oh = 3'h1;
         BMC_ARB_MODE1: s_d.arb_oh = 3'h2;
         BMC_ARB_MODE2: s_d.arb_oh = 3'h4;
         default:       s_d.arb_oh = 3'h0;
      endcase

      // Data RAM address setup sequencing
      case (s_q.dst)
         BMC_DR_IDLE: begin
            if (cpu_dram_req) begin
               if (s_q.wait_st) begin
                  s_d.dst  = BMC_DR_WAIT; // [RULE6]
                  s_d.wcnt = BMC_DRAM_WAIT_CYC;
               end else begin
                  s_d.ack = 1'b1; // [RULE6]
               end
            end
         end
         BMC_DR_WAIT: begin
            // Requests are not accepted until the ack
            if (s_q.wcnt == 2'h1) begin
               s_d.ack = 1'b1;
               s_d.dst = BMC_DR_IDLE;
               s_d.wcnt = 2'h0;
            end else begin
               s_d.wcnt = s_q.wcnt - 2'h1;
            end
         end
         default: begin
            s_d.dst  = BMC_DR_IDLE;
            s_d.wcnt = 2'h0;
         end
      endcase
   end

   // ---------------------------------------------
   // Registers
   // ---------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         s_q.err_en  <= BMC_RST_ERR_EN; // [RULE11]
         s_q.wait_st <= BMC_RST_WAIT; // [RULE11]
         s_q.arb     <= BMC_RST_ARB; // [RULE8]
         s_q.sts     <= 5'h00;
         s_q.msk     <= 5'h00;
         s_q.rdata   <= 32'h0000_0000;
         s_q.ready   <= 1'b0;
         s_q.slverr  <= 1'b0;
         s_q.berr    <= 5'h00;
         s_q.arb_oh  <= 3'h2; // [RULE8]
         s_q.irq     <= 1'b0;
         s_q.ack     <= 1'b0;
         s_q.wcnt    <= 2'h0;
         s_q.dst     <= BMC_DR_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------
   // Outputs
   // ---------------------------------------------
   assign prdata               = s_q.rdata;
   assign pready               = s_q.ready;
   assign pslverr              = s_q.slverr;
   assign bus_error            = s_q.berr;
   assign cpu_dram_ack         = s_q.ack;
   assign arbitration_mode_sel = s_q.arb;
   assign arb_mode_onehot      = s_q.arb_oh;
   assign data_ram_wait_state  = s_q.wait_st;
   assign irq                  = s_q.irq;
endmodule
`default_nettype wire

/* bmc_initiators.sv */
`default_nettype none
module bmc_initiators (
   // Commands from the bench
   input  wire logic       clock,
   input  wire logic [4:0] fire,
   input  wire logic       dbg,
   input  wire logic       req,
   // Towards the block
   output logic      [4:0] unmapped_access,
   output logic            cpu_debug_mode,
   output logic            cpu_dram_req
);
   // Copies of the commands delayed by one cycle, launched just after the edge
   always_ff @(posedge clock) begin
      unmapped_access <= fire;
      cpu_debug_mode  <= dbg;
      cpu_dram_req    <= req;
   end
endmodule
`default_nettype wire

/* bmc_top_assertions.sv */
`default_nettype none
module bmc_checker (
   // Clock, reset and APB
   input wire logic                          clock,
   input wire logic                          rst,
   input wire logic                          psel,
   input wire logic                          penable,
   input wire logic                          pwrite,
   input wire logic [bmc_pkg::BMC_ADDR_W-1:0] paddr,
   input wire logic [31:0]                   pwdata,
   input wire logic [31:0]                   prdata,
   input wire logic                          pready,
   // Initiators and matrix
   input wire logic [bmc_pkg::BMC_NINIT-1:0] unmapped_access,
   input wire logic                          cpu_debug_mode,
   input wire logic [bmc_pkg::BMC_NINIT-1:0] bus_error,
   input wire logic                          cpu_dram_req,
   input wire logic                          cpu_dram_ack,
   input wire logic [2:0]                    arbitration_mode_sel,
   input wire logic [2:0]                    arb_mode_onehot,
   input wire logic                          data_ram_wait_state,
   input wire logic                          irq
);
   import bmc_pkg::*;
   logic [31:0] cfg_q;
   logic        acc;
   assign acc = psel && penable && pready && paddr == BMC_OFS_CFG;
   // Shadow keeps only implemented bits, so reads prove the rest are zero
   always_ff @(posedge clock) begin
      if (rst) cfg_q <= 32'h001F_0041;
      else if (acc && pwrite) cfg_q <= pwdata & 32'h001F_0047;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   property p_e4; bus_error[4] == $past(unmapped_access[4] && cfg_q[20]); endproperty
   a_e4: assert property (p_e4) else $error("shared bus error wrong");
   property p_e3; bus_error[3] == $past(unmapped_access[3] && cfg_q[19]); endproperty
   a_e3: assert property (p_e3) else $error("debug unit error missing");
   property p_e2; bus_error[2] == $past(unmapped_access[2] && cfg_q[18]); endproperty
   a_e2: assert property (p_e2) else $error("dma error wrong");
   property p_e1;
      bus_error[1] == $past(unmapped_access[1] && cfg_q[17] && !cpu_debug_mode);
   endproperty
   a_e1: assert property (p_e1) else $error("cpu data error wrong");
   property p_e0;
      bus_error[0] == $past(unmapped_access[0] && cfg_q[16] && !cpu_debug_mode);
   endproperty
   a_e0: assert property (p_e0) else $error("cpu fetch error wrong");
   property p_wait;
      cpu_dram_req |-> if (data_ram_wait_state) ##1 !cpu_dram_ack ##1 cpu_dram_ack
                       else ##1 cpu_dram_ack;
   endproperty
   a_wait: assert property (p_wait) else $error("data ram ack timing wrong");
   property p_arb;
      arb_mode_onehot == (arbitration_mode_sel > 3'h2 ? 3'h0 : 3'h1 << arbitration_mode_sel);
   endproperty
   a_arb: assert property (p_arb) else $error("arbitration mode wrong");
   property p_rst; $past(rst) |-> arbitration_mode_sel == 3'h1 && data_ram_wait_state; endproperty
   a_rst: assert property (p_rst) else $error("reset config wrong");
   property p_rd; acc && !pwrite |-> prdata == cfg_q; endproperty
   a_rd: assert property (p_rd) else $error("config read wrong");
   c_err: cover property (bus_error[4]);
   c_ws: cover property (cpu_dram_req && data_ram_wait_state);
   c_irq: cover property ($rose(irq));
endmodule
bind bmc_top bmc_checker u_chk (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .unmapped_access, .cpu_debug_mode, .bus_error, .cpu_dram_req,
   .cpu_dram_ack, .arbitration_mode_sel, .arb_mode_onehot, .data_ram_wait_state, .irq);
`default_nettype wire

/* bus_matrix_config_bench.sv */
`default_nettype none
module bus_matrix_config_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import bmc_pkg::*;
   logic        clock, rst, psel, penable, pwrite, pready, pslverr, irq, dbg, req;
   logic        cpu_debug_mode, cpu_dram_req, cpu_dram_ack, data_ram_wait_state;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rnd;
   logic [4:0]  fire, unmapped_access, bus_error, exp5;
   logic [2:0]  arbitration_mode_sel, arb_mode_onehot;
   logic [32:0] expq[$];
   int          num_errors = 0, num_checks = 0, n;
   bmc_top u_dut (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .unmapped_access, .cpu_debug_mode, .bus_error, .cpu_dram_req, .cpu_dram_ack,
      .arbitration_mode_sel, .arb_mode_onehot, .data_ram_wait_state, .irq);
   bmc_initiators u_ini (.clock, .fire, .dbg, .req, .unmapped_access, .cpu_debug_mode,
      .cpu_dram_req);
   always #10 clock = ~clock;
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction
   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Reads note {pslverr, prdata} in the queue; writes send d[31:0]
   task automatic apb(input logic wr, input logic [11:0] a, input logic [32:0] d);
      if (!wr) expq.push_back(d);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d[31:0];
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock iff pready === 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
      // Idle edge keeps psel from being driven twice in one step
      @(posedge clock);
   endtask
   always @(posedge clock) begin
      if (psel && penable && pready === 1'b1 && !pwrite)
         chk({pslverr, prdata}, expq.pop_front());
   end
   initial begin
      #100us;
      num_errors++;
      end_of_test();
   end
   initial begin
      clock   = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0000_0000;
      fire    = 5'h00;
      dbg     = 1'b0;
      req     = 1'b0;
      rst = 1'b1;
      rnd = 32'd16821;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      apb(0, BMC_OFS_CFG, 33'h0001F_0041);
      apb(1, BMC_OFS_CFG, 33'h0FFFF_FFFA);
      apb(0, BMC_OFS_CFG, 33'h0001F_0042);
      apb(0, 12'h00C, 33'h1_0000_0000);
      // Only the three defined codes are ever written
      for (int m = 0; m < 3; m++) begin
         apb(1, BMC_OFS_CFG, 33'(m));
         repeat (2) @(posedge clock);
         chk(33'({arbitration_mode_sel, arb_mode_onehot}), 33'({3'(m), 3'(1 << m)}));
      end
      for (int i = 0; i < 8; i++) begin
         rnd = xs(rnd);
         apb(1, BMC_OFS_CFG, {12'h0, rnd[4:0], 16'h0041});
         apb(1, BMC_OFS_MSK, 33'(rnd[9:5]));
         apb(1, BMC_OFS_STS, 33'h1F);
         dbg  <= rnd[10];
         fire <= 5'h1F;
         @(posedge clock);
         fire <= 5'h00;
         repeat (4) @(posedge clock);
         exp5 = rnd[4:0] & ~(rnd[10] ? 5'h03 : 5'h00);
         apb(0, BMC_OFS_STS, 33'(exp5));
         chk(33'(irq), 33'(|(exp5 & rnd[9:5])));
      end
      for (int w = 0; w < 2; w++) begin
         apb(1, BMC_OFS_CFG, 33'(w << 6));
         req <= 1'b1;
         @(posedge clock);
         req <= 1'b0;
         n = 0;
         do begin
            @(posedge clock);
            n++;
         end while (cpu_dram_ack !== 1'b1 && n < 9);
         chk(33'(n), 33'(w + 2));
      end
      // Mid-run reset must restore the defaults
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      apb(0, BMC_OFS_CFG, 33'h0001F_0041);
      repeat (2) @(posedge clock);
      end_of_test();
   end
endmodule
`default_nettype wire
